// >>> bench/spiflt_slave_model.sv
/*
  Behavioural far-side slave for master-mode runs, clock polarity 0.
  Assumes the bench pulses load before each byte and sets the phase.
*/
`timescale 1ns/1ps
module spiflt_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic phase,
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int cnt = 8;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  always @(posedge load) begin
    cnt = 0;
    miso = phase ? ~miso : tx_byte[7];
  end
  always @(posedge sck) begin
    if (phase && cnt < 8) begin
      miso = tx_byte[7 - cnt];
      cnt = cnt + 1;
    end else if (!phase && cnt < 8) begin
      rx_byte = {rx_byte[6:0], mosi};
    end
  end
  // Released line flips so a stale bit never matches by luck
  always @(negedge sck) begin
    if (phase) begin
      rx_byte = {rx_byte[6:0], mosi};
      if (cnt == 8) miso = ~miso;
    end else if (cnt < 8) begin
      cnt = cnt + 1;
      miso = (cnt < 8) ? tx_byte[7 - cnt] : ~miso;
    end
  end
endmodule : spiflt_slave_model

// >>> bench/spiflt_top_test.sv
/*
  Self-checking bench: register map, master transfers at all rates, flags.
  Assumes the slave model as far side; wires resolved here from enables.
*/
`timescale 1ns/1ps
module spiflt_top_test;
  logic aclk = 1'b0, aresetn = 1'b0, ss_n_i = 1'b1, phase = 1'b1, load = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pm_tx = 8'h00, pm_rx, rv;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serial_clock_pin_o, serial_clock_pin_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic rx_err_irq, pm_miso;
  logic fm_sck = 1'b0, fm_mosi = 1'b0;
  logic [15:0] lfsr = 16'd11249;
  int fails = 0, samples_checked = 0;
  wire sck_w = serial_clock_pin_oe ? serial_clock_pin_o : fm_sck;
  wire mosi_w = mosi_oe ? mosi_o : fm_mosi;
  wire miso_w = miso_oe ? miso_o : pm_miso;
  spiflt_top spiflt_top_inst (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_pin_i(sck_w),
    .serial_clock_pin_o, .serial_clock_pin_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe,
    .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i, .rx_err_irq);
  spiflt_slave_model spiflt_slave_model_inst (.sck(sck_w), .mosi(mosi_w), .phase, .load,
    .tx_byte(pm_tx), .miso(pm_miso), .rx_byte(pm_rx));
  always #12.5 aclk = ~aclk;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  function automatic int bit_time(input int r, input logic ph);
    return (2 << (2 * r)) + (ph ? 0 : (1 << (2 * r)));
  endfunction : bit_time
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // Bounded handshake; a lost answer ends the run
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (n >= 50) begin fails++; wrap_up(); end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rv = s_axi_rdata[7:0];
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (n >= 50) begin fails++; wrap_up(); end
  endtask : rd
  // Polls status until the masked bit sets; status read is the clear's first step
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin tick(16); rd(spiflt_pkg::ADDR_STATUS); n++; end while (!rv[b] && n < 100);
    if (n >= 100) begin fails++; wrap_up(); end
  endtask : poll
  task automatic start(input int r, output logic [7:0] tx);
    int n;
    pm_tx <= rnd();
    load <= 1'b1;
    tx = rnd();
    @(posedge aclk);
    load <= 1'b0;
    wr(spiflt_pkg::ADDR_DATA, tx);
    n = 0;
    while (serial_clock_pin_o !== 1'b1 && n < 400) begin @(posedge aclk); n++; end
    chk("start delay ok", n <= bit_time(r, phase), 1);
  endtask : start
  // Far master for slave runs: 200 ns link clock, phase 0, polarity 0
  task automatic far_master(input logic [7:0] d, input int nb, output logic [7:0] got);
    got = 8'h00;
    ss_n_i <= 1'b0;
    tick(8);
    for (int i = 7; i > 7 - nb; i--) begin
      fm_mosi <= d[i];
      tick(4);
      got = {got[6:0], miso_w};
      fm_sck <= 1'b1;
      tick(4);
      fm_sck <= 1'b0;
    end
    tick(8);
    ss_n_i <= 1'b1;
    tick(8);
  endtask : far_master
  initial begin
    logic [7:0] t1, t2, p1;
    int n;
    tick(10);
    aresetn <= 1'b1;
    rd(spiflt_pkg::ADDR_CONTROL);
    chk("control reset", rv, spiflt_pkg::CTL_RESET);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("status reset", rv, spiflt_pkg::STAT_RESET);
    rd(8'h4c);
    chk("unmapped resp", s_axi_rresp, spiflt_pkg::RESP_SLVERR);
    for (int r = 0; r < 4; r++) begin
      phase <= r[0];
      wr(spiflt_pkg::ADDR_CONTROL, 8'h02);
      wr(spiflt_pkg::ADDR_STATUS, 8'h44 | 8'(r));
      wr(spiflt_pkg::ADDR_CONTROL, 8'h12 | {4'h0, r[0], 3'h0});
      start(r, t1);
      poll(spiflt_pkg::ST_RX_FULL);
      rd(spiflt_pkg::ADDR_DATA);
      chk("rx byte", rv, pm_tx);
      chk("far side byte", pm_rx, t1);
      rd(spiflt_pkg::ADDR_STATUS);
      chk("rx full cleared", rv[7], 1'b0);
    end
    start(3, t1);
    p1 = pm_tx;
    poll(spiflt_pkg::ST_RX_FULL);
    start(3, t2);
    poll(spiflt_pkg::ST_OVERFLOW);
    chk("error irq", rx_err_irq, 1'b1);
    n = 0;
    while (pm_rx !== t2 && n < 4000) begin
      tick(1);
      n++;
    end
    if (n >= 4000) begin
      fails++;
      wrap_up();
    end
    tick(300);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("full and overflow", {rv[7], rv[5]}, 2'h3);
    rd(spiflt_pkg::ADDR_DATA);
    chk("old byte kept", rv, p1);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("overflow cleared", {rv[7], rv[5]}, 2'h0);
    ss_n_i <= 1'b0;
    tick(8);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("mode fault", rv[4], 1'b1);
    chk("fault irq", rx_err_irq, 1'b1);
    ss_n_i <= 1'b1;
    tick(8);
    wr(spiflt_pkg::ADDR_CONTROL, 8'h1a);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("mode fault cleared", rv[4], 1'b0);
    wr(spiflt_pkg::ADDR_STATUS, 8'h40);
    ss_n_i <= 1'b0;
    tick(8);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("fault blocked", rv[4], 1'b0);
    ss_n_i <= 1'b1;
    wr(spiflt_pkg::ADDR_STATUS, 8'h44);
    wr(spiflt_pkg::ADDR_CONTROL, 8'h10);
    t1 = rnd();
    t2 = rnd();
    wr(spiflt_pkg::ADDR_DATA, t1);
    far_master(t2, 8, p1);
    chk("slave miso byte", p1, t1);
    chk("miso released", miso_oe, 1'b0);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("slave rx full", rv[7], 1'b1);
    rd(spiflt_pkg::ADDR_DATA);
    chk("slave rx byte", rv, t2);
    far_master(t1, 3, p1);
    rd(spiflt_pkg::ADDR_STATUS);
    chk("slave deselect fault", rv[4], 1'b1);
    wrap_up();
  end
endmodule : spiflt_top_test

// >>> rtl/spiflt_pkg.sv
/*
  Constants, register map and state type of the serial shift unit.
  Assumes nothing; shared by the top module and the bench.
*/
package spiflt_pkg;
  localparam int ADDR_W = 8;
  // Printed offsets are register indices; byte address is four times each
  localparam int IDX_CONTROL = 32'h0000_0010;
  localparam int IDX_STATUS = 32'h0000_0011;
  localparam int IDX_DATA = 32'h0000_0012;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(IDX_CONTROL * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_DATA = ADDR_W'(IDX_DATA * 4);
  // Control register fields
  localparam int CTL_RX_IRQ_EN = 0;
  localparam int CTL_MASTER = 1;
  localparam int CTL_POLARITY = 2;
  localparam int CTL_PHASE = 3;
  localparam int CTL_ENABLE = 4;
  localparam logic [7:0] CTL_RESET = 8'h08;
  // Status and control register fields
  localparam int ST_RATE_LO = 0;
  localparam int ST_MF_CHECK_EN = 2;
  localparam int ST_MODE_FAULT = 4;
  localparam int ST_OVERFLOW = 5;
  localparam int ST_ERR_IRQ_EN = 6;
  localparam int ST_RX_FULL = 7;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Half bit time in bus cycles per rate setting; a bit time is twice this
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_RATE_DIVIDE_MAX = 7'h40;
  localparam logic [3:0] HALVES_PER_BYTE = 4'h0;
  localparam logic [3:0] LAST_CAPTURE = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {XF_IDLE, XF_BUSY, XF_WAIT_DESEL} spiflt_xfer_e;
endpackage : spiflt_pkg

// >>> rtl/spiflt_sync.sv
/*
  Two-flop synchroniser for pin inputs, one lane per bit.
  Assumes inputs are asynchronous to aclk; output is only the second flop.
*/
`timescale 1ns/1ps
module spiflt_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta <= RESET_VAL[i];
          dout[i] <= RESET_VAL[i];
        end else if (ce) begin
          meta <= din[i];
          dout[i] <= meta;
        end
      end
    end
  endgenerate
endmodule : spiflt_sync

// >>> rtl/spiflt_top.sv
/*
  Serial shift unit, master and slave, with AXI4-Lite register access,
  both clock phase formats, start latency and overflow / mode fault flags.
  Assumes pin inputs are asynchronous and the bench resolves the wires.
*/
// Behaviour
// - Phase 0: ss fall starts, MSB first captured
// - Slave drives miso only while selected
// - Phase 1: first clock edge starts, drives data
// - Phase 1: ss may stay low across bytes
// - Master starts only on data write
// - Phase 0 idle first half; phase 1 edge
// - Divider free-runs only when enabled and master
// - Clock edges placed on bus clock grid
// - Start delay at most one bit time
// - Overflow set at first capture when full
// - Overflow keeps old byte, drops new one
// - Overflow raises error interrupt when enabled
// - One shared error enable; check enable gates
// - Mode fault settable only with check enable
// - Mode fault interrupt shares one request line
// - Mode fault flags ss level conflict
// - No receive full while overflow pending
// - Receive full clears: status then data read
// - Mode fault clears: status read, control write
// - Slave fault when ss rises mid transfer
`timescale 1ns/1ps
module spiflt_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [spiflt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [spiflt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  output logic rx_err_irq
);
  logic rx_irq_en, master_select, clock_polarity_select, clock_phase_select, module_enable_bit;
  logic [1:0] rate_select;
  logic mode_fault_check_enable, error_irq_enable;
  logic receive_full_flag, overflow_flag, mode_fault_flag;
  logic rxf_arm, ovf_arm, mode_fault_flag_arm;
  logic [7:0] rx_data, tx_buf, sh, next_sh;
  logic tx_pending, cap_bit;
  logic [3:0] cnt;
  logic [6:0] presc, half;
  spiflt_pkg::spiflt_xfer_e xf;
  logic sck_s, mosi_s, miso_s, ss_n_s, sck_d, ss_n_d;
  logic aw_got, w_got;
  logic [spiflt_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;

  spiflt_sync #(.W(4), .RESET_VAL(4'h8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .din({ss_n_i, miso_i, mosi_i, serial_clock_pin_i}),
    .dout({ss_n_s, miso_s, mosi_s, sck_s})
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_d <= 1'b0;
      ss_n_d <= 1'b1;
    end else if (ce) begin
      sck_d <= sck_s;
      ss_n_d <= ss_n_s;
    end
  end

  // Master clock divider and transfer events
  logic clk_run, tick, m_mode, slv, m_start, m_step, m_cap, m_shf, m_done;
  logic [3:0] cnt_next;
  logic sck_lead, sck_trail, ss_fall, s_start, s_cap, s_shf, s_done;
  logic start, cap, shf, done, first_cap, in_bit, mode_fault_flag_cond;
  logic [7:0] rx_byte;
  logic [1:0] mcap_d, mdone_d;
  logic [7:0] mrx, rx_val;
  logic rx_done;
  always_comb begin
    unique case (rate_select)
      2'h0: half = spiflt_pkg::HALF_DIV2;
      2'h1: half = spiflt_pkg::HALF_DIV8;
      2'h2: half = spiflt_pkg::HALF_DIV32;
      2'h3: half = spiflt_pkg::HALF_RATE_DIVIDE_MAX;
    endcase
  end
  assign m_mode = module_enable_bit && master_select;
  assign slv = module_enable_bit && !master_select;
  assign clk_run = m_mode;
  assign tick = clk_run && (presc == half - 7'h01);
  assign cnt_next = cnt + 4'h1;
  assign m_start = tick && xf == spiflt_pkg::XF_IDLE && tx_pending;
  assign m_step = tick && xf == spiflt_pkg::XF_BUSY;
  assign m_done = m_step && cnt_next == spiflt_pkg::HALVES_PER_BYTE;
  assign m_cap = m_step && cnt_next[0];
  assign m_shf = m_step && !cnt_next[0] && !m_done;
  assign sck_lead = sck_s != sck_d && sck_s == !clock_polarity_select;
  assign sck_trail = sck_s != sck_d && sck_s == clock_polarity_select;
  assign ss_fall = ss_n_d && !ss_n_s;
  // Slave ignores the clock while deselected
  assign s_start = slv && xf == spiflt_pkg::XF_IDLE && !ss_n_s &&
                   (clock_phase_select ? sck_lead : ss_fall);
  assign s_cap = slv && xf == spiflt_pkg::XF_BUSY && !ss_n_s &&
                 (clock_phase_select ? sck_trail : sck_lead);
  assign s_shf = slv && xf == spiflt_pkg::XF_BUSY && !ss_n_s &&
                 (clock_phase_select ? sck_lead : sck_trail);
  assign s_done = s_cap && cnt == spiflt_pkg::LAST_CAPTURE;
  assign start = m_start || s_start;
  assign cap = m_cap || s_cap;
  assign shf = m_shf || s_shf;
  assign done = m_done || s_done;
  assign first_cap = (m_cap && cnt_next == 4'h1) || (s_cap && cnt == 4'h0);
  assign in_bit = master_select ? miso_s : mosi_s;
  assign rx_byte = {sh[6:0], in_bit};
  assign rx_done = mdone_d[1] || s_done;
  assign rx_val = mdone_d[1] ? mrx : rx_byte;
  assign mode_fault_flag_cond = mode_fault_check_enable && ((m_mode && !ss_n_s) ||
                     (slv && xf == spiflt_pkg::XF_BUSY && ss_n_s));

  always_comb begin
    next_sh = sh;
    if (start) begin
      next_sh = tx_pending ? tx_buf : sh;
    end else if (done) begin
      next_sh = rx_byte;
    end else if (shf) begin
      next_sh = {sh[6:0], cap_bit};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc <= 7'h00;
    end else if (ce) begin
      if (!clk_run || tick) begin
        presc <= 7'h00;
      end else begin
        presc <= presc + 7'h01;
      end
    end
  end

  // Master reads miso two cycles late to cover the synchroniser; divide-by-2 needs it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcap_d <= 2'h0;
      mdone_d <= 2'h0;
      mrx <= 8'h00;
    end else if (ce) begin
      mcap_d <= {mcap_d[0], m_cap};
      mdone_d <= {mdone_d[0], m_done};
      if (mcap_d[1]) begin
        mrx <= {mrx[6:0], miso_s};
      end
    end
  end

  // Transfer sequencing and shifter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xf <= spiflt_pkg::XF_IDLE;
      cnt <= 4'h0;
      sh <= spiflt_pkg::DATA_RESET;
      cap_bit <= 1'b0;
    end else if (ce) begin
      sh <= next_sh;
      if (cap) begin
        cap_bit <= in_bit;
      end
      if (!module_enable_bit || mode_fault_flag_cond) begin
        xf <= spiflt_pkg::XF_IDLE;
      end else begin
        unique case (xf)
          spiflt_pkg::XF_IDLE: begin
            if (start) begin
              xf <= spiflt_pkg::XF_BUSY;
              cnt <= 4'h0;
            end
          end
          spiflt_pkg::XF_BUSY: begin
            if (m_step) begin
              cnt <= cnt_next;
            end else if (s_cap) begin
              cnt <= cnt_next;
            end
            if (m_done || (s_done && clock_phase_select)) begin
              xf <= spiflt_pkg::XF_IDLE;
            end else if (s_done) begin
              xf <= spiflt_pkg::XF_WAIT_DESEL;
            end
          end
          spiflt_pkg::XF_WAIT_DESEL: begin
            if (ss_n_s) begin
              xf <= spiflt_pkg::XF_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_pin_o <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else if (ce) begin
      serial_clock_pin_oe <= m_mode;
      mosi_oe <= m_mode;
      miso_oe <= slv && !ss_n_s;
      mosi_o <= next_sh[7];
      miso_o <= next_sh[7];
      if (!m_mode || mode_fault_flag_cond || m_done) begin
        serial_clock_pin_o <= clock_polarity_select;
      end else if (m_start) begin
        serial_clock_pin_o <= clock_phase_select ^ clock_polarity_select;
      end else if (m_step) begin
        serial_clock_pin_o <= (cnt_next[0] ^ clock_phase_select) ^ clock_polarity_select;
      end
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  logic do_wr, do_rd, wr_ok, rd_ok;
  logic [7:0] rd_val;
  assign do_wr = aw_got && w_got && !s_axi_bvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign wr_ok = aw_addr == spiflt_pkg::ADDR_CONTROL || aw_addr == spiflt_pkg::ADDR_STATUS ||
                 aw_addr == spiflt_pkg::ADDR_DATA;
  assign rd_ok = s_axi_araddr == spiflt_pkg::ADDR_CONTROL ||
                 s_axi_araddr == spiflt_pkg::ADDR_STATUS || s_axi_araddr == spiflt_pkg::ADDR_DATA;
  always_comb begin
    rd_val = 8'h00;
    if (s_axi_araddr == spiflt_pkg::ADDR_CONTROL) begin
      rd_val = {3'h0, module_enable_bit, clock_phase_select, clock_polarity_select,
                master_select, rx_irq_en};
    end else if (s_axi_araddr == spiflt_pkg::ADDR_STATUS) begin
      rd_val = {receive_full_flag, error_irq_enable, overflow_flag, mode_fault_flag, 1'b0,
                mode_fault_check_enable, rate_select};
    end else if (s_axi_araddr == spiflt_pkg::ADDR_DATA) begin
      rd_val = rx_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spiflt_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= spiflt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? spiflt_pkg::RESP_OKAY : spiflt_pkg::RESP_SLVERR;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (do_rd) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_ok ? spiflt_pkg::RESP_OKAY : spiflt_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  logic wr_ctl, wr_st, wr_dat, rd_st, rd_dat;
  assign wr_ctl = do_wr && w_lane0 && aw_addr == spiflt_pkg::ADDR_CONTROL;
  assign wr_st = do_wr && w_lane0 && aw_addr == spiflt_pkg::ADDR_STATUS;
  assign wr_dat = do_wr && w_lane0 && aw_addr == spiflt_pkg::ADDR_DATA;
  assign rd_st = do_rd && s_axi_araddr == spiflt_pkg::ADDR_STATUS;
  assign rd_dat = do_rd && s_axi_araddr == spiflt_pkg::ADDR_DATA;

  // Control fields; a master mode fault drops the enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {module_enable_bit, clock_phase_select, clock_polarity_select, master_select,
       rx_irq_en} <= spiflt_pkg::CTL_RESET[4:0];
      error_irq_enable <= spiflt_pkg::STAT_RESET[spiflt_pkg::ST_ERR_IRQ_EN];
      mode_fault_check_enable <= spiflt_pkg::STAT_RESET[spiflt_pkg::ST_MF_CHECK_EN];
      rate_select <= spiflt_pkg::STAT_RESET[1:0];
    end else if (ce) begin
      if (wr_ctl) begin
        rx_irq_en <= w_data[spiflt_pkg::CTL_RX_IRQ_EN];
        master_select <= w_data[spiflt_pkg::CTL_MASTER];
        clock_polarity_select <= w_data[spiflt_pkg::CTL_POLARITY];
        clock_phase_select <= w_data[spiflt_pkg::CTL_PHASE];
        module_enable_bit <= w_data[spiflt_pkg::CTL_ENABLE];
      end
      if (mode_fault_flag_cond && master_select) begin
        module_enable_bit <= 1'b0;
      end
      if (wr_st) begin
        error_irq_enable <= w_data[spiflt_pkg::ST_ERR_IRQ_EN];
        mode_fault_check_enable <= w_data[spiflt_pkg::ST_MF_CHECK_EN];
        rate_select <= w_data[spiflt_pkg::ST_RATE_LO +: 2];
      end
    end
  end

  // Transmit buffer; a write landing on a start stays pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf <= spiflt_pkg::DATA_RESET;
      tx_pending <= 1'b0;
    end else if (ce) begin
      if (start || (mode_fault_flag_cond && master_select)) begin
        tx_pending <= 1'b0;
      end
      if (wr_dat) begin
        tx_buf <= w_data;
        tx_pending <= 1'b1;
      end
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_full_flag <= 1'b0;
      overflow_flag <= 1'b0;
      mode_fault_flag <= 1'b0;
      rxf_arm <= 1'b0;
      ovf_arm <= 1'b0;
      mode_fault_flag_arm <= 1'b0;
      rx_data <= spiflt_pkg::DATA_RESET;
    end else if (ce) begin
      if (rd_st) begin
        rxf_arm <= receive_full_flag;
        ovf_arm <= overflow_flag;
        mode_fault_flag_arm <= mode_fault_flag;
      end
      if (rd_dat && rxf_arm) begin
        receive_full_flag <= 1'b0;
        rxf_arm <= 1'b0;
      end
      if (rd_dat && ovf_arm) begin
        overflow_flag <= 1'b0;
        ovf_arm <= 1'b0;
      end
      if (wr_ctl && mode_fault_flag_arm && !mode_fault_flag_cond) begin
        mode_fault_flag <= 1'b0;
        mode_fault_flag_arm <= 1'b0;
      end
      if (mode_fault_flag_cond) begin
        mode_fault_flag <= 1'b1;
        mode_fault_flag_arm <= 1'b0;
      end
      if (first_cap && receive_full_flag) begin
        overflow_flag <= 1'b1;
      end
      if (rx_done && !receive_full_flag && !overflow_flag) begin
        rx_data <= rx_val;
        receive_full_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_err_irq <= 1'b0;
    end else if (ce) begin
      rx_err_irq <= (receive_full_flag && rx_irq_en && module_enable_bit) ||
                    (error_irq_enable && (overflow_flag || mode_fault_flag));
    end
  end

  // Helper: cycles a master write waits before its transfer starts
  logic [7:0] wait_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt <= 8'h00;
    end else if (ce) begin
      wait_cnt <= (tx_pending && m_mode && xf == spiflt_pkg::XF_IDLE && !start) ?
                  wait_cnt + 8'h01 : 8'h00;
    end
  end

  AST_MISO_SELECT: assert property (@(posedge aclk) disable iff (!aresetn)
    miso_oe |-> !master_select && !$past(ss_n_s)) else $error("miso driven while deselected");
  AST_START_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
    wait_cnt <= {half, 1'b0}) else $error("master start later than one bit time");
  AST_PHASE0_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && m_start && !clock_phase_select |=> serial_clock_pin_o == clock_polarity_select)
    else $error("phase 0 clock left idle too early");
  AST_PHASE1_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && m_start && clock_phase_select |=> serial_clock_pin_o != clock_polarity_select)
    else $error("phase 1 missing opening edge");
  AST_OVF_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rx_done && overflow_flag |=> rx_data == $past(rx_data)) else $error("byte lost order");
  AST_ERR_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && error_irq_enable && (overflow_flag || mode_fault_flag) |=> rx_err_irq)
    else $error("error interrupt missing");
  AST_MODE_FAULT_FLAG_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_fault_check_enable && !mode_fault_flag |=> !mode_fault_flag)
    else $error("mode fault set while check disabled");
  AST_RXF_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow_flag && !receive_full_flag |=> !receive_full_flag)
    else $error("receive full set during overflow");
  AST_SLAVE_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && slv && xf == spiflt_pkg::XF_BUSY && ss_n_s && mode_fault_check_enable
    |=> mode_fault_flag) else $error("slave deselect fault missed");
  AST_CLK_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !m_mode |-> !tick && serial_clock_pin_oe == $past(serial_clock_pin_oe) || !$past(ce) ||
    !serial_clock_pin_oe) else $error("divider ran while not master");
  AST_WRITE_START: assert property (@(posedge aclk) disable iff (!aresetn)
    m_start |-> tx_pending) else $error("master start without data write");
  COV_OVERFLOW: cover property (@(posedge aclk) disable iff (!aresetn) $rose(overflow_flag));
  COV_MODE_FAULT_FLAG: cover property (@(posedge aclk) disable iff (!aresetn) $rose(mode_fault_flag));
  COV_MASTER_DONE: cover property (@(posedge aclk) disable iff (!aresetn) ce && m_done);
  COV_SLAVE_DONE: cover property (@(posedge aclk) disable iff (!aresetn) ce && s_done);
endmodule : spiflt_top
